// file: rtl/exp_alert.sv
// Change-alert unit: compares input pins against last read levels
`timescale 1ns/1ps
module exp_alert (
  input wire logic   clk,
  input wire logic   rst_n,
  exp_alert_if.unit  a
);
  import exp_pkg::*;
  localparam int ALV_MAX = ALERT_CYC;
  // Two sync flops, the filter run and a little margin
  localparam logic [3:0] SETTLE_END = 4'(FILT_CYC + 4);
  logic [PINS-1:0] snap_reg;
  logic            primed_reg;
  logic [3:0]      settle_reg;
  logic            alert_reg;
  logic [1:0]      pend;
  // ----------------------------------------
  // Snapshot per 8-pin port
  // ----------------------------------------
  // Filtered pins start at zero, so wait until they show the real levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 4'h0;
      primed_reg <= 1'b0;
    end else begin
      if (settle_reg != SETTLE_END) begin
        settle_reg <= settle_reg + 4'h1;
      end
      primed_reg <= (settle_reg == SETTLE_END);
    end
  end
  for (genvar p = 0; p < 2; p++) begin : g_port
    // Snapshot follows the pins until settled, so no alert at start-up
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        snap_reg[p*8 +: 8] <= 8'h00;
      end else if (!primed_reg || a.clr[p]) begin
        snap_reg[p*8 +: 8] <= a.pin_lvl[p*8 +: 8];
      end
    end
    // Only input-mode pins may differ; return to old level clears
    assign pend[p] = primed_reg &&
      |((a.pin_lvl[p*8 +: 8] ^ snap_reg[p*8 +: 8]) & a.watch[p*8 +: 8]);
  end
  // Registered so the pin driver comes straight from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |pend;
    end
  end
  assign a.alert = alert_reg;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_in_change;
    primed_reg && a.clr == 2'b00 && |((a.pin_lvl ^ $past(a.pin_lvl)) & a.watch);
  endsequence
  AST_ALERT_IN_TIME: assert property (@(posedge clk) disable iff (!rst_n)
    s_in_change ##0 (pend != 2'b00) |-> ##[1:ALV_MAX] alert_reg)
    else $error("alert not raised after input change");
  AST_OUTPUT_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    (((a.pin_lvl ^ snap_reg) & a.watch) == 16'h0000) |=> !alert_reg)
    else $error("alert raised by an output pin");
  AST_PORT_ISOLATED: assert property (@(posedge clk) disable iff (!rst_n)
    (a.clr == 2'b10) |=> (snap_reg[7:0] == $past(snap_reg[7:0])))
    else $error("port 1 read reloaded port 0 snapshot");
endmodule

// file: rtl/exp_alert_if.sv
// Carrier between the bus core and the change-alert unit
`timescale 1ns/1ps
interface exp_alert_if;
  logic [exp_pkg::PINS-1:0] pin_lvl;
  logic [exp_pkg::PINS-1:0] watch;
  logic [1:0]               clr;
  logic                     alert;
  modport core (output pin_lvl, output watch, output clr, input alert);
  modport unit (input pin_lvl, input watch, input clr, output alert);
endinterface

// file: rtl/exp_core.sv
// Two-wire slave core of a 16-bit remote I/O expander
`timescale 1ns/1ps
// Summary of operation
// - Reset pin low holds all defaults
// - Power-on reset initialises registers and bus
// - Input pins have both drivers off
// - Output pins follow output latch bits
// - Input pin edge raises alert promptly
// - Alert clears on level return or read
// - Read clear at ack bit after rise
// - Later changes raise the alert again
// - Outputs and foreign writes never alert
// - Output to input switch may alert
// - Alert clearing is tracked per port
// - Alert is open-drain, pulls low only
// - Command 00h plus foreign read ack clears
// - Start is data fall while clock high
// - Address MSB first, general call ignored
// - Matching address acked low during high
// - Data changes only while clock low
// - Stop is data rise, return idle
// - Each byte gets one acknowledge bit
// - Master nack ends read, release data
// - Address 1110 1 plus two selects
// - Command low bits pick register 0..7
// - Input register reads pin levels XOR polarity bits
// - Direction 1 input, 0 output
module exp_core (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     por_n,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe,
  input  wire logic                     addr_select_lo,
  input  wire logic                     addr_select_hi,
  input  wire logic [exp_pkg::PINS-1:0] io_i,
  output logic      [exp_pkg::PINS-1:0] io_o,
  output logic      [exp_pkg::PINS-1:0] io_oe,
  output logic                          alert_o,
  output logic                          alert_oe
);
  import exp_pkg::*;
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_s_n;
  logic any_rst_n;
  assign any_rst_n = rst_n & por_n;
  // Either source resets at once, release is synchronous
  always_ff @(posedge clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_s_n      <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_s_n      <= rst_meta_reg;
    end
  end
  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  logic [19:0]     raw;
  logic [19:0]     filt;
  logic [PINS-1:0] pins_f;
  logic            scl;
  logic            sda;
  logic            a_lo;
  logic            a_hi;
  assign raw = {addr_select_hi, addr_select_lo, sda_i, scl_i, io_i};
  exp_sync #(
    .W    (20),
    .FILT (FILT_CYC),
    .RST  (SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_s_n),
    .d     (raw),
    .q     (filt)
  );
  assign pins_f = filt[15:0];
  assign scl    = filt[16];
  assign sda    = filt[17];
  assign a_lo   = filt[18];
  assign a_hi   = filt[19];
  // ----------------------------------------
  // Bus edge and condition detection
  // ----------------------------------------
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end
  assign scl_rise = scl & ~scl_d_reg;
  assign scl_fall = ~scl & scl_d_reg;
  // Data moving under a high clock is framing, never a bit
  assign start_c  = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop_c   = scl & scl_d_reg & ~sda_d_reg & sda;
  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  exp_state_t      state_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      sh_reg;
  logic            rw_reg;
  logic            first_reg;
  logic            nack_reg;
  logic            cmd_zero_reg;
  logic [2:0]      ptr_reg;
  logic [PINS-1:0] out_reg;
  logic [PINS-1:0] pol_reg;
  logic [PINS-1:0] dir_out_reg;
  logic [1:0]      clr_reg;
  logic            sda_oe_reg;
  logic            lo_reg;
  logic            addr_hit;
  logic            commit;
  logic            rd_next;
  // Address is fixed prefix plus the two select pins
  assign addr_hit = (sh_reg[7:1] == {ADDR_FIXED, a_hi, a_lo}) &&
                    (sh_reg[7:1] != GEN_CALL);
  assign commit  = scl_fall && state_reg == S_WR && cnt_reg == 4'h8;
  assign rd_next = scl_fall && state_reg == S_RD_ACK && !nack_reg;
  // Read value of one register; inputs show the pins flipped by the polarity bits
  function automatic logic [7:0] reg_val(input logic [2:0] idx);
    logic [3:0] l;
    l = {idx[0], 3'h0};
    case (idx[2:1])
      PAIR_IN:  reg_val = pins_f[l +: 8] ^ pol_reg[l +: 8];
      PAIR_OUT: reg_val = out_reg[l +: 8];
      PAIR_POL: reg_val = pol_reg[l +: 8];
      default:  reg_val = ~dir_out_reg[l +: 8];
    endcase
  endfunction
  // Byte for the next read slot; a call result cannot be bit-selected
  logic [7:0] rd_byte;
  assign rd_byte = reg_val(rd_next ? {ptr_reg[2:1], ~ptr_reg[0]} : ptr_reg);
  // ----------------------------------------
  // Slave state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      nack_reg  <= 1'b0;
    end else if (stop_c) begin
      state_reg <= S_IDLE;
    end else if (start_c) begin
      state_reg <= S_ADDR;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        S_ADDR, S_WR, S_RD: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (scl_fall && cnt_reg == 4'h8) begin
            cnt_reg <= 4'h0;
            if (state_reg == S_ADDR) begin
              rw_reg    <= sh_reg[0];
              state_reg <= addr_hit ? S_ADDR_ACK : S_OTHER_ACK;
            end else begin
              state_reg <= (state_reg == S_WR) ? S_WR_ACK : S_RD_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            first_reg <= 1'b1;
            state_reg <= rw_reg ? S_RD : S_WR;
          end
        end
        S_WR_ACK: begin
          if (scl_fall) begin
            first_reg <= 1'b0;
            state_reg <= S_WR;
          end
        end
        S_RD_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda;
          end
          if (scl_fall) begin
            state_reg <= nack_reg ? S_WAIT : S_RD;
          end
        end
        S_OTHER_ACK: begin
          if (scl_fall) begin
            state_reg <= S_WAIT;
          end
        end
        default: begin
        end
      endcase
    end
  end
  // ----------------------------------------
  // Shifter and data line drive
  // ----------------------------------------
  // Drive is set only on a clock fall and released at a start or stop, so the line is stable while high
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sh_reg     <= 8'h00;
      sda_oe_reg <= 1'b0;
    end else if (stop_c || start_c) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_rise && (state_reg == S_ADDR || state_reg == S_WR)) begin
      sh_reg <= {sh_reg[6:0], sda};
    end else if (scl_fall) begin
      case (state_reg)
        S_ADDR: sda_oe_reg <= (cnt_reg == 4'h8) && addr_hit;
        S_WR:   sda_oe_reg <= (cnt_reg == 4'h8);
        S_ADDR_ACK, S_RD_ACK: begin
          if (state_reg == S_ADDR_ACK && !rw_reg || nack_reg && state_reg == S_RD_ACK) begin
            sda_oe_reg <= 1'b0;
          end else begin
            sda_oe_reg <= ~rd_byte[7];
            sh_reg     <= {rd_byte[6:0], 1'b0};
          end
        end
        S_RD: begin
          // Master owns the ack slot after the eighth bit
          sda_oe_reg <= (cnt_reg != 4'h8) && !sh_reg[7];
          sh_reg     <= {sh_reg[6:0], 1'b0};
        end
        default: sda_oe_reg <= 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // Pointer and writable registers
  // ----------------------------------------
  // Pairs toggle the low bit so a burst alternates port 0 and 1
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ptr_reg      <= PTR_RST;
      cmd_zero_reg <= 1'b0;
    end else if (commit && first_reg) begin
      ptr_reg      <= sh_reg[2:0];
      cmd_zero_reg <= (sh_reg == ERR_CMD);
    end else if (commit || rd_next) begin
      ptr_reg <= {ptr_reg[2:1], ~ptr_reg[0]};
    end
  end
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      out_reg     <= OUT_RST;
      pol_reg     <= POL_RST;
      dir_out_reg <= ~CFG_RST;
    end else if (commit && !first_reg) begin
      case (ptr_reg[2:1])
        PAIR_OUT: out_reg[{ptr_reg[0], 3'h0} +: 8] <= sh_reg;
        PAIR_POL: pol_reg[{ptr_reg[0], 3'h0} +: 8] <= sh_reg;
        PAIR_CFG: dir_out_reg[{ptr_reg[0], 3'h0} +: 8] <= ~sh_reg;
        default: begin
        end
      endcase
    end
  end
  // ----------------------------------------
  // Alert clearing
  // ----------------------------------------
  // Clears fire on the ack clock rise; a change in that cycle is lost
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      clr_reg <= 2'b00;
    end else if (scl_rise && state_reg == S_RD_ACK && ptr_reg[2:1] == PAIR_IN) begin
      clr_reg <= ptr_reg[0] ? 2'b10 : 2'b01;
    end else if (scl_rise && state_reg == S_OTHER_ACK && rw_reg && !sda && cmd_zero_reg) begin
      clr_reg <= 2'b01;
    end else begin
      clr_reg <= 2'b00;
    end
  end
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      lo_reg <= 1'b0;
    end else begin
      lo_reg <= 1'b0;
    end
  end
  exp_alert_if u_if ();
  assign u_if.pin_lvl = pins_f;
  assign u_if.watch   = ~dir_out_reg;
  assign u_if.clr     = clr_reg;
  exp_alert u_alert (
    .clk   (clk),
    .rst_n (rst_s_n),
    .a     (u_if.unit)
  );
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign io_o     = out_reg;
  assign io_oe    = dir_out_reg;
  assign sda_o    = lo_reg;
  assign sda_oe   = sda_oe_reg;
  assign alert_o  = lo_reg;
  assign alert_oe = u_if.alert;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_s_n);
  sequence s_wr_data;
    commit && !first_reg;
  endsequence
  sequence s_foreign_rd_ack;
    scl_rise && state_reg == S_OTHER_ACK && rw_reg && !sda;
  endsequence
  AST_RESET_DEFAULTS: assert property ($rose(rst_s_n) |-> io_o == OUT_RST && io_oe == 16'h0000)
    else $error("defaults wrong after reset");
  AST_START_ADDR: assert property (start_c && !stop_c |=> state_reg == S_ADDR && cnt_reg == 4'h0)
    else $error("start not taken");
  AST_STOP_IDLE: assert property (stop_c |=> state_reg == S_IDLE && !sda_oe)
    else $error("stop did not release bus");
  AST_ADDR_ACK: assert property (state_reg == S_ADDR_ACK && scl |-> sda_oe)
    else $error("address ack not held");
  AST_CFG_WRITE: assert property (s_wr_data ##0 (ptr_reg[2:1] == PAIR_CFG) |=>
    io_oe[{$past(ptr_reg[0]), 3'h0} +: 8] == ~$past(sh_reg))
    else $error("direction write lost");
  AST_OUT_WRITE: assert property (s_wr_data ##0 (ptr_reg[2:1] == PAIR_OUT) |=>
    io_o[{$past(ptr_reg[0]), 3'h0} +: 8] == $past(sh_reg))
    else $error("output latch write lost");
  AST_NACK_RELEASE: assert property (state_reg == S_RD_ACK && scl_fall && nack_reg |=>
    !sda_oe && state_reg == S_WAIT)
    else $error("data line held after nack");
  AST_ERRATA_CLEAR: assert property (s_foreign_rd_ack ##0 cmd_zero_reg && !stop_c && !start_c |=>
    clr_reg == 2'b01)
    else $error("foreign read did not clear port 0");
  AST_READ_CLEAR: assert property (scl_rise && state_reg == S_RD_ACK && ptr_reg == 3'h1 && !stop_c && !start_c
    |=> clr_reg == 2'b10 ##1 clr_reg == 2'b00)
    else $error("port 1 read clear wrong");
endmodule

// file: rtl/exp_pkg.sv
// Shared constants and types of the I/O expander core
package exp_pkg;
  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int PINS           = 16;
  localparam int CLK_MHZ        = 100;
  localparam int SPIKE_NS       = 50;
  localparam int FILT_CYC       = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int ALERT_VALID_NS = 4000;
  localparam int ALERT_CYC      = (ALERT_VALID_NS * CLK_MHZ) / 1000;
  // ----------------------------------------
  // Addressing and register indexes
  // ----------------------------------------
  localparam logic [4:0] ADDR_FIXED = 5'h1d;
  localparam logic [6:0] GEN_CALL   = 7'h00;
  localparam logic [1:0] PAIR_IN    = 2'h0;
  localparam logic [1:0] PAIR_OUT   = 2'h1;
  localparam logic [1:0] PAIR_POL   = 2'h2;
  localparam logic [1:0] PAIR_CFG   = 2'h3;
  localparam logic [7:0] ERR_CMD    = 8'h00;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [2:0]  PTR_RST = 3'h0;
  localparam logic [19:0] SYNC_RST = 20'h3_0000;
  typedef enum {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK,
    S_RD, S_RD_ACK, S_OTHER_ACK, S_WAIT
  } exp_state_t;
endpackage

// file: rtl/exp_sync.sv
// Two-flop synchroniser with per-bit glitch filter
`timescale 1ns/1ps
module exp_sync #(
  parameter int            W    = 20,
  parameter int            FILT = 5,
  parameter logic [W-1:0]  RST  = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  localparam int CW = $clog2(FILT + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT - 1);
  // ----------------------------------------
  // One filter per bit
  // ----------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic          m1_reg;
    logic          m2_reg;
    logic          q_reg;
    logic [CW-1:0] cnt_reg;
    // A level must hold FILT cycles before it is believed
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        m1_reg  <= RST[i];
        m2_reg  <= RST[i];
        q_reg   <= RST[i];
        cnt_reg <= '0;
      end else begin
        m1_reg <= d[i];
        m2_reg <= m1_reg;
        if (m2_reg == q_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
          q_reg   <= m2_reg;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign q[i] = q_reg;
  end
endmodule

// file: tb/exp_mst.sv
// Behavioural two-wire bus master that drives the expander's bus pins
`timescale 1ns/1ps
module exp_mst (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv
);
  // ----------------------------------------
  // Bus phases: 160 ns bit, 100 ns low, 60 ns high
  // ----------------------------------------
  logic fake_ack;  // Another slave answers in the ack slot

  // Both lines released at time zero, so the bus idles high
  initial begin
    scl_drv  = 1'b0;
    sda_drv  = 1'b0;
    fake_ack = 1'b0;
  end

  // Wait whole cycles; all changes land on the falling clock edge
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start; also used after a stop, where both lines are already high
  task automatic start();
    sda_drv = 1'b0;
    w(4);
    scl_drv = 1'b0;
    w(6);
    sda_drv = 1'b1;
    w(6);
    scl_drv = 1'b1;
    w(3);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_drv = 1'b1;
    w(7);
    scl_drv = 1'b0;
    w(6);
    sda_drv = 1'b0;
    w(8);
  endtask

  // One bit; data moves well inside the low phase so the slave's late release cannot look like a stop
  task automatic bit_x(input logic b, output logic r);
    sda_drv = !b;
    w(7);
    scl_drv = 1'b0;
    w(6);
    r = sda;
    scl_drv = 1'b1;
    w(3);
  endtask

  // Byte out, most significant bit first, then the ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(!fake_ack, ack);
  endtask

  // Byte in; the last one is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// file: tb/i2c_port_expander_core_tb_top.sv
// Self-checking bench of the expander core against the bus master model
`timescale 1ns/1ps
module i2c_port_expander_core_tb_top;
  import exp_pkg::*;
  `define CHK(e, a) begin exp_q.push_back(16'(e)); got = 16'(a); ->res_ev; #1; end

  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  logic        clk, rst_n, por_n, addr_select_lo, addr_select_hi;
  logic        sda_o, sda_oe, alert_o, alert_oe, m_scl, m_sda, ack;
  logic [15:0] ext, io_i, io_o, io_oe, cfg_e, out_e, got, e;
  logic [15:0] exp_q [$];
  logic [7:0]  b0, b1;
  logic [6:0]  dev;
  logic [6:0]  bad [2] = '{7'h00, 7'h76};
  int          fails, n_tests;
  integer      seed;
  event        res_ev;
  wire         sda = !(m_sda || sda_oe);
  wire         scl = !m_scl;

  // Pin wire: driven pins follow the latch, others the outside world
  assign io_i = (io_oe & io_o) | (~io_oe & ext);

  exp_core exp_core_i (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi), .io_i(io_i), .io_o(io_o),
    .io_oe(io_oe), .alert_o(alert_o), .alert_oe(alert_oe)
  );
  exp_mst exp_mst_i (.clk(clk), .sda(sda), .scl_drv(m_scl), .sda_drv(m_sda));

  // 100 MHz system clock
  always #5 clk = ~clk;

  // Result watcher: oldest note against each result as it appears
  always @(res_ev) begin
    e = exp_q.pop_front();
    n_tests++;
    if (got !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Expected pin levels from the bench's own view of direction and latch
  function automatic logic [15:0] pin_e();
    return (~cfg_e & out_e) | (cfg_e & ext);
  endfunction

  // Write: address, then up to three bytes, the first being the command
  task automatic wr(input logic [6:0] a, input int n, input logic [7:0] c, d0 = 0, d1 = 0);
    logic [7:0] bq [3];
    bq = '{c, d0, d1};
    exp_mst_i.start();
    exp_mst_i.wbyte({a, 1'b0}, ack);
    `CHK(0, ack)
    for (int i = 0; i < n; i++) begin
      exp_mst_i.wbyte(bq[i], ack);
      `CHK(0, ack)
    end
    exp_mst_i.stop();
  endtask

  // Read one or two input port bytes starting at command c
  task automatic rd(input logic [7:0] c, input int n);
    logic [15:0] p;
    logic [7:0]  d;
    wr(dev, 1, c);
    p = pin_e();
    exp_mst_i.start();
    exp_mst_i.wbyte({dev, 1'b1}, ack);
    `CHK(0, ack)
    exp_mst_i.rbyte(n == 1, d);
    `CHK(c[0] ? p[15:8] : p[7:0], d)
    if (n == 2) begin
      exp_mst_i.rbyte(1'b1, d);
      `CHK(p[15:8], d)
    end
    exp_mst_i.stop();
  endtask

  // Read addressed to some other slave, which acknowledges it
  task automatic foreign();
    exp_mst_i.fake_ack = 1'b1;
    exp_mst_i.start();
    exp_mst_i.wbyte(8'h41, ack);
    exp_mst_i.fake_ack = 1'b0;
    exp_mst_i.stop();
  endtask

  // Wait a bounded time for the alert level; a lapse ends the run
  task automatic al(input logic v);
    int k;
    k = 0;
    repeat (20) @(negedge clk);
    while (alert_oe !== v && k < ALERT_CYC - 20) begin
      @(negedge clk);
      k++;
    end
    `CHK(v, alert_oe)
    `CHK(0, {sda_o, alert_o})
    if (k >= ALERT_CYC - 20)
      close_out();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    por_n = 1'b0;
    fails = 0;
    n_tests = 0;
    seed = 32'hbe80;
    addr_select_lo = 1'b0;
    addr_select_hi = 1'b0;
    ext = 16'($random(seed));
    cfg_e = 16'hffff;
    out_e = 16'hffff;
    repeat (15) @(negedge clk);
    `CHK(OUT_RST, io_o)
    `CHK(0, io_oe)
    `CHK(0, {alert_oe, sda_oe})
    @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    repeat (30) @(negedge clk);
    `CHK(0, alert_oe)
    // Every select setting, changed only between transfers
    for (int s = 0; s < 4; s++) begin
      {addr_select_hi, addr_select_lo} = 2'(s);
      dev = 7'h74 + 7'(s);
      repeat (20) @(negedge clk);
      wr(dev, 0, 8'h00);
    end
    // General call and a neighbour's address stay unanswered
    foreach (bad[i]) begin
      exp_mst_i.start();
      exp_mst_i.wbyte({bad[i], 1'b0}, ack);
      `CHK(1, ack)
      exp_mst_i.stop();
    end
    wr(dev, 3, 8'h06, 8'hf0, 8'hff);
    cfg_e = 16'hfff0;
    `CHK(16'h000f, io_oe)
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    wr(dev, 3, 8'h03, b1, b0);
    out_e = {b1, b0};
    `CHK({b1, b0}, io_o)
    rd(8'h00, 2);
    ext[4] = ~ext[4];
    al(1'b1);
    ext[4] = ~ext[4];
    al(1'b0);
    b0 = ~b0;
    wr(dev, 2, 8'h02, b0);
    out_e[7:0] = b0;
    al(1'b0);
    ext[8] = ~ext[8];
    al(1'b1);
    foreign();
    al(1'b1);
    rd(8'h00, 1);
    al(1'b1);
    rd(8'h01, 1);
    al(1'b0);
    ext[9] = ~ext[9];
    al(1'b1);
    rd(8'h01, 1);
    al(1'b0);
    wr(dev, 1, 8'h00);
    ext[5] = ~ext[5];
    al(1'b1);
    foreign();
    al(1'b0);
    wr(dev, 1, 8'h02);
    ext[5] = ~ext[5];
    al(1'b1);
    foreign();
    al(1'b1);
    rd(8'h00, 1);
    al(1'b0);
    ext[0] = ~out_e[0];
    al(1'b0);
    wr(dev, 2, 8'h06, 8'hf1);
    cfg_e[0] = 1'b1;
    al(1'b1);
    por_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(OUT_RST, io_o)
    `CHK(0, io_oe)
    `CHK(0, {alert_oe, sda_oe})
    por_n = 1'b1;
    repeat (5) @(negedge clk);
    close_out();
  end
endmodule
